// ---- logic/pif_pkg.sv ----
// Behaviour
// - each flag is set by its event, regardless of any enable bit.
// - group 4 bit 4 is unimplemented, reads zero, ignores writes.
// - group 4 holds cell, waveform, oscillator, -, capture, timer2, gate, timer1 flags.
// - group 5 bits 5..0 hold DMA2 abort/overrun/dest/src, comparator 2, ext irq 1.
// - group 5 bits 7..6 are read-only I2C unit 2 transmit and receive flags.
// - ext irq 1 event comes from the gpio chosen by the pin select register.
// - every implemented flag resets to zero on any reset.
package pif_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PIN_N  = 8;
  localparam int unsigned SEL_W  = 3;

  // register offsets
  localparam logic [ADDR_W-1:0] OFF_FLAGS_GROUP4 = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_FLAGS_GROUP5 = 4'h1;
  localparam logic [ADDR_W-1:0] OFF_MASK_GROUP4  = 4'h2;
  localparam logic [ADDR_W-1:0] OFF_MASK_GROUP5  = 4'h3;
  localparam logic [ADDR_W-1:0] OFF_PIN_SELECT   = 4'h4;

  // field positions, group 4
  localparam int unsigned BIT_LOGIC_CELL1      = 7;
  localparam int unsigned BIT_WAVEFORM_GEN1    = 6;
  localparam int unsigned BIT_NUM_OSC1         = 5;
  localparam int unsigned BIT_G4_UNUSED        = 4;
  localparam int unsigned BIT_CAPTURE_COMPARE1 = 3;
  localparam int unsigned BIT_TIMER2           = 2;
  localparam int unsigned BIT_TIMER1_GATE      = 1;
  localparam int unsigned BIT_TIMER1           = 0;

  // field positions, group 5
  localparam int unsigned BIT_I2C2_TX          = 7;
  localparam int unsigned BIT_I2C2_RX          = 6;
  localparam int unsigned BIT_DMA2_ABORT       = 5;
  localparam int unsigned BIT_DMA2_OVERRUN     = 4;
  localparam int unsigned BIT_DMA2_DEST_COUNT  = 3;
  localparam int unsigned BIT_DMA2_SRC_COUNT   = 2;
  localparam int unsigned BIT_COMPARATOR2      = 1;
  localparam int unsigned BIT_EXT_IRQ1         = 0;

  // pin select fields
  localparam int unsigned BIT_PIN_FALLING      = 3;
  localparam logic [DATA_W-1:0] PIN_SELECT_MASK = 8'h0F;

  // software-writable bits and implemented bits
  localparam logic [DATA_W-1:0] G4_WR_MASK = 8'hEF;
  localparam logic [DATA_W-1:0] G5_WR_MASK = 8'h3F;
  localparam logic [DATA_W-1:0] G5_RO_MASK = 8'hC0;

  // values after reset
  localparam logic [DATA_W-1:0] RST_FLAGS      = 8'h00;
  localparam logic [DATA_W-1:0] RST_MASK       = 8'h00;
  localparam logic [DATA_W-1:0] RST_PIN_SELECT = 8'h00;
  localparam logic [DATA_W-1:0] RD_IDLE        = 8'h00;

endpackage

// ---- logic/pif_ext_pin.sv ----
`timescale 1ns/10ps
module pif_ext_pin
  import pif_pkg::*;
(
  input  wire logic             clock_i,
  input  wire logic             reset_n_i,
  input  wire logic [PIN_N-1:0] gpio_pins_i,
  input  wire logic [SEL_W-1:0] pin_index_i,
  input  wire logic             falling_i,
  output logic                  edge_o
);

  logic sel_level;
  logic prev_level;
  logic primed;

  // the selected pin, inverted when falling edges are chosen
  assign sel_level = gpio_pins_i[pin_index_i] ^ falling_i;

  // primed stops a pin already high at reset release from looking like an edge
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      primed     <= 1'b0;
      prev_level <= 1'b0;
    end else begin
      primed     <= 1'b1;
      prev_level <= sel_level;
    end
  end

  // a change of pin index may itself look like an edge; software selects first
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      edge_o <= 1'b0;
    end else begin
      edge_o <= primed & sel_level & ~prev_level;
    end
  end

endmodule

// ---- logic/pif_flags.sv ----
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module pif_flags
  import pif_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              reset_n_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  input  wire logic              logic_cell1_evt_i,
  input  wire logic              waveform_gen1_evt_i,
  input  wire logic              num_osc1_evt_i,
  input  wire logic              capture_compare1_evt_i,
  input  wire logic              timer2_evt_i,
  input  wire logic              timer1_gate_evt_i,
  input  wire logic              timer1_evt_i,
  input  wire logic              dma_ch2_abort_evt_i,
  input  wire logic              dma_ch2_overrun_evt_i,
  input  wire logic              dma_ch2_dest_count_evt_i,
  input  wire logic              dma_ch2_src_count_evt_i,
  input  wire logic              comparator2_evt_i,
  input  wire logic              i2c_unit2_tx_cond_i,
  input  wire logic              i2c_unit2_rx_cond_i,
  input  wire logic [PIN_N-1:0]  gpio_pins_i,
  output logic      [DATA_W-1:0] flags_group4_o,
  output logic      [DATA_W-1:0] flags_group5_o,
  output logic                   irq_o
);

  logic [DATA_W-1:0] periph_irq_flags_group4;
  logic [DATA_W-1:0] periph_irq_flags_group5;
  logic [DATA_W-1:0] irq_mask_group4;
  logic [DATA_W-1:0] irq_mask_group5;
  logic [DATA_W-1:0] ext_irq_pin_select_reg;

  logic [DATA_W-1:0] next_group4;
  logic [DATA_W-1:0] next_group5;
  logic [DATA_W-1:0] next_mask4;
  logic [DATA_W-1:0] next_mask5;
  logic [DATA_W-1:0] set_group4;
  logic [DATA_W-1:0] set_group5;
  logic [DATA_W-1:0] read_value;
  logic              ext_irq1_edge;
  logic              wr_group4;
  logic              wr_group5;
  logic              wr_mask4;
  logic              wr_mask5;
  logic              wr_pin_sel;

  // one decode serves both the write strobes and the read mux
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] off);
    reg_hit = (a == off);
  endfunction

  assign wr_group4  = wr_i & reg_hit(addr_i, OFF_FLAGS_GROUP4);
  assign wr_group5  = wr_i & reg_hit(addr_i, OFF_FLAGS_GROUP5);
  assign wr_mask4   = wr_i & reg_hit(addr_i, OFF_MASK_GROUP4);
  assign wr_mask5   = wr_i & reg_hit(addr_i, OFF_MASK_GROUP5);
  assign wr_pin_sel = wr_i & reg_hit(addr_i, OFF_PIN_SELECT);

  pif_ext_pin u_ext_pin (
    .clock_i     (clock_i),
    .reset_n_i   (reset_n_i),
    .gpio_pins_i (gpio_pins_i),
    .pin_index_i (ext_irq_pin_select_reg[SEL_W-1:0]),
    .falling_i   (ext_irq_pin_select_reg[BIT_PIN_FALLING]),
    .edge_o      (ext_irq1_edge)
  );

  // event vectors laid out as the registers; no enable takes part
  always_comb begin
    set_group4                       = RST_FLAGS;
    set_group4[BIT_LOGIC_CELL1]      = logic_cell1_evt_i;
    set_group4[BIT_WAVEFORM_GEN1]    = waveform_gen1_evt_i;
    set_group4[BIT_NUM_OSC1]         = num_osc1_evt_i;
    set_group4[BIT_CAPTURE_COMPARE1] = capture_compare1_evt_i;
    set_group4[BIT_TIMER2]           = timer2_evt_i;
    set_group4[BIT_TIMER1_GATE]      = timer1_gate_evt_i;
    set_group4[BIT_TIMER1]           = timer1_evt_i;
  end

  always_comb begin
    set_group5                      = RST_FLAGS;
    set_group5[BIT_DMA2_ABORT]      = dma_ch2_abort_evt_i;
    set_group5[BIT_DMA2_OVERRUN]    = dma_ch2_overrun_evt_i;
    set_group5[BIT_DMA2_DEST_COUNT] = dma_ch2_dest_count_evt_i;
    set_group5[BIT_DMA2_SRC_COUNT]  = dma_ch2_src_count_evt_i;
    set_group5[BIT_COMPARATOR2]     = comparator2_evt_i;
    set_group5[BIT_EXT_IRQ1]        = ext_irq1_edge;
  end

  // set wins over a write of zero; the unused bit is forced low
  assign next_group4 = G4_WR_MASK &
                       (set_group4 | (wr_group4 ? wdata_i : periph_irq_flags_group4));

  // read-only pair mirrors the I2C unit, cleared only there
  assign next_group5 = (G5_RO_MASK & {i2c_unit2_tx_cond_i, i2c_unit2_rx_cond_i, 6'h00}) |
                       (G5_WR_MASK &
                        (set_group5 | (wr_group5 ? wdata_i : periph_irq_flags_group5)));

  assign next_mask4 = wr_mask4 ? wdata_i : irq_mask_group4;
  assign next_mask5 = wr_mask5 ? wdata_i : irq_mask_group5;

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      periph_irq_flags_group4 <= RST_FLAGS;
      periph_irq_flags_group5 <= RST_FLAGS;
    end else begin
      periph_irq_flags_group4 <= next_group4;
      periph_irq_flags_group5 <= next_group5;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      irq_mask_group4 <= RST_MASK;
      irq_mask_group5 <= RST_MASK;
    end else begin
      irq_mask_group4 <= next_mask4;
      irq_mask_group5 <= next_mask5;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      ext_irq_pin_select_reg <= RST_PIN_SELECT;
    end else if (wr_pin_sel) begin
      ext_irq_pin_select_reg <= wdata_i & PIN_SELECT_MASK;
    end
  end

  // outputs toward the vectoring logic, registered copies of the flags
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      flags_group4_o <= RST_FLAGS;
      flags_group5_o <= RST_FLAGS;
    end else begin
      flags_group4_o <= next_group4;
      flags_group5_o <= next_group5;
    end
  end

  // built from next values so irq_o moves in the same cycle as the flags
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((next_group4 & next_mask4) | (next_group5 & next_mask5));
    end
  end

  always_comb begin
    read_value = RD_IDLE;
    if (reg_hit(addr_i, OFF_FLAGS_GROUP4)) begin
      read_value = periph_irq_flags_group4;
    end else if (reg_hit(addr_i, OFF_FLAGS_GROUP5)) begin
      read_value = periph_irq_flags_group5;
    end else if (reg_hit(addr_i, OFF_MASK_GROUP4)) begin
      read_value = irq_mask_group4;
    end else if (reg_hit(addr_i, OFF_MASK_GROUP5)) begin
      read_value = irq_mask_group5;
    end else if (reg_hit(addr_i, OFF_PIN_SELECT)) begin
      read_value = ext_irq_pin_select_reg;
    end
  end

  // read data stand one cycle only, zero otherwise and for unmapped addresses
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      rdata_o <= RD_IDLE;
    end else if (rd_i) begin
      rdata_o <= read_value;
    end else begin
      rdata_o <= RD_IDLE;
    end
  end

  logic sel_level_chk;
  assign sel_level_chk = gpio_pins_i[ext_irq_pin_select_reg[SEL_W-1:0]] ^
                         ext_irq_pin_select_reg[BIT_PIN_FALLING];

  sequence s_g4_events;
    (set_group4 & G4_WR_MASK) != 8'h00;
  endsequence

  property p_set_beats_clear;
    @(posedge clock_i) disable iff (!reset_n_i)
      s_g4_events |=>
        ((periph_irq_flags_group4 & $past(set_group4 & G4_WR_MASK)) ==
         $past(set_group4 & G4_WR_MASK));
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear)
    else $error("group4 event lost");

  property p_g5_set;
    @(posedge clock_i) disable iff (!reset_n_i)
      (set_group5 != 8'h00) |=>
        ((periph_irq_flags_group5 & $past(set_group5)) == $past(set_group5));
  endproperty
  a_g5_set: assert property (p_g5_set)
    else $error("group5 event lost");

  property p_bit4_zero;
    @(posedge clock_i) disable iff (!reset_n_i)
      (wr_group4 && wdata_i[BIT_G4_UNUSED]) |=>
        (!periph_irq_flags_group4[BIT_G4_UNUSED] &&
         !flags_group4_o[BIT_G4_UNUSED]);
  endproperty
  a_bit4_zero: assert property (p_bit4_zero)
    else $error("group4 bit 4 took a write");

  property p_g4_write;
    @(posedge clock_i) disable iff (!reset_n_i)
      (wr_group4 && set_group4 == 8'h00) |=>
        (periph_irq_flags_group4 == ($past(wdata_i) & G4_WR_MASK));
  endproperty
  a_g4_write: assert property (p_g4_write)
    else $error("group4 write not stored");

  property p_g5_write;
    @(posedge clock_i) disable iff (!reset_n_i)
      (wr_group5 && set_group5 == 8'h00) |=>
        ((periph_irq_flags_group5 & G5_WR_MASK) == ($past(wdata_i) & G5_WR_MASK));
  endproperty
  a_g5_write: assert property (p_g5_write)
    else $error("group5 write not stored");

  property p_i2c_mirror;
    @(posedge clock_i) disable iff (!reset_n_i)
      $past(reset_n_i) |->
        (periph_irq_flags_group5[BIT_I2C2_TX:BIT_I2C2_RX] ==
         {$past(i2c_unit2_tx_cond_i), $past(i2c_unit2_rx_cond_i)});
  endproperty
  a_i2c_mirror: assert property (p_i2c_mirror)
    else $error("i2c flags do not follow the unit");

  sequence s_pin_edge;
    $past(reset_n_i) && $stable(ext_irq_pin_select_reg) && $rose(sel_level_chk);
  endsequence

  property p_ext_pin;
    @(posedge clock_i) disable iff (!reset_n_i)
      s_pin_edge |-> ##2 periph_irq_flags_group5[BIT_EXT_IRQ1];
  endproperty
  a_ext_pin: assert property (p_ext_pin)
    else $error("selected pin edge did not set ext irq flag");

  property p_reset_zero;
    @(posedge clock_i)
      !reset_n_i |=>
        (periph_irq_flags_group4 == 8'h00 &&
         (periph_irq_flags_group5 & G5_WR_MASK) == 8'h00 && !irq_o);
  endproperty
  a_reset_zero: assert property (p_reset_zero)
    else $error("flags not cleared by reset");

  property p_irq_level;
    @(posedge clock_i) disable iff (!reset_n_i)
      ##1 (irq_o == |((periph_irq_flags_group4 & irq_mask_group4) |
                      (periph_irq_flags_group5 & irq_mask_group5)));
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("irq output disagrees with masked flags");

  sequence s_read_then_idle;
    rd_i ##1 !rd_i;
  endsequence

  property p_read_slot;
    @(posedge clock_i) disable iff (!reset_n_i)
      s_read_then_idle |=> (rdata_o == RD_IDLE);
  endproperty
  a_read_slot: assert property (p_read_slot)
    else $error("read data outside its slot");

  property p_read_data;
    @(posedge clock_i) disable iff (!reset_n_i)
      rd_i |=> (rdata_o == $past(read_value));
  endproperty
  a_read_data: assert property (p_read_data)
    else $error("read data differ from the addressed register");

  // offsets above the pin select register are unmapped
  property p_read_unmapped;
    @(posedge clock_i) disable iff (!reset_n_i)
      (rd_i && addr_i > OFF_PIN_SELECT) |=> (rdata_o == RD_IDLE);
  endproperty
  a_read_unmapped: assert property (p_read_unmapped)
    else $error("unmapped read returned data");

  property p_bit4_read;
    @(posedge clock_i) disable iff (!reset_n_i)
      (rd_i && reg_hit(addr_i, OFF_FLAGS_GROUP4)) |=> !rdata_o[BIT_G4_UNUSED];
  endproperty
  a_bit4_read: assert property (p_bit4_read)
    else $error("group4 bit 4 read as one");

  property p_g4_hold;
    @(posedge clock_i) disable iff (!reset_n_i)
      (!wr_group4 && set_group4 == 8'h00) |=> $stable(periph_irq_flags_group4);
  endproperty
  a_g4_hold: assert property (p_g4_hold)
    else $error("group4 changed without write or event");

  property p_g5_hold;
    @(posedge clock_i) disable iff (!reset_n_i)
      (!wr_group5 && set_group5 == 8'h00) |=>
        $stable(periph_irq_flags_group5 & G5_WR_MASK);
  endproperty
  a_g5_hold: assert property (p_g5_hold)
    else $error("group5 changed without write or event");

  // a hardware source for the pin flag other than the detector would be a leak
  property p_ext_source;
    @(posedge clock_i) disable iff (!reset_n_i)
      $rose(periph_irq_flags_group5[BIT_EXT_IRQ1]) |->
        ($past(ext_irq1_edge) || $past(wr_group5 && wdata_i[BIT_EXT_IRQ1]));
  endproperty
  a_ext_source: assert property (p_ext_source)
    else $error("ext irq flag set without a pin edge");

  property p_pin_sel_upper;
    @(posedge clock_i) disable iff (!reset_n_i)
      ((ext_irq_pin_select_reg & ~PIN_SELECT_MASK) == 8'h00);
  endproperty
  a_pin_sel_upper: assert property (p_pin_sel_upper)
    else $error("pin select upper bits not zero");

  // a mask write in the same cycle could legally hold the line low
  property p_irq_rises;
    @(posedge clock_i) disable iff (!reset_n_i)
      ((((set_group4 & G4_WR_MASK & irq_mask_group4) |
         (set_group5 & irq_mask_group5)) != 8'h00) && !wr_mask4 && !wr_mask5) |=> irq_o;
  endproperty
  a_irq_rises: assert property (p_irq_rises)
    else $error("unmasked event did not raise irq");

  property p_flags_out;
    @(posedge clock_i) disable iff (!reset_n_i)
      (flags_group4_o == periph_irq_flags_group4) &&
      (flags_group5_o == periph_irq_flags_group5);
  endproperty
  a_flags_out: assert property (p_flags_out)
    else $error("flag outputs differ from the registers");

  property p_mask_write;
    @(posedge clock_i) disable iff (!reset_n_i)
      wr_mask4 |=> (irq_mask_group4 == $past(wdata_i));
  endproperty
  a_mask_write: assert property (p_mask_write)
    else $error("group4 mask write not stored");

endmodule

// ---- tb/pif_src_model.sv ----
`timescale 1ns/10ps
module pif_src_model
  import pif_pkg::*;
(
  input  wire logic             clock_i,
  input  wire logic             reset_n_i,
  input  wire logic [7:0]       fire4_i,
  input  wire logic [5:1]       fire5_i,
  input  wire logic [PIN_N-1:0] pins_i,
  input  wire logic             tx_ready_i,
  input  wire logic             rx_ready_i,
  input  wire logic             clear_buffers_bit_i,
  output logic      [7:0]       evt4_o,
  output logic      [5:1]       evt5_o,
  output logic      [PIN_N-1:0] gpio_o,
  output logic                  tx_cond_o,
  output logic                  rx_cond_o
);
  // peripherals raise one-cycle event strobes, enables play no part
  always_ff @(posedge clock_i) begin
    evt4_o <= reset_n_i ? fire4_i : 8'h00;
    evt5_o <= reset_n_i ? fire5_i : 5'h00;
  end
  always_ff @(posedge clock_i) begin
    gpio_o <= reset_n_i ? pins_i : 8'h00;
  end
  // the condition lasts until the buffers are flushed, not until a flag write
  always_ff @(posedge clock_i) begin
    if (!reset_n_i || clear_buffers_bit_i) begin
      tx_cond_o <= 1'b0;
      rx_cond_o <= 1'b0;
    end else begin
      tx_cond_o <= tx_cond_o | tx_ready_i;
      rx_cond_o <= rx_cond_o | rx_ready_i;
    end
  end
endmodule

// ---- tb/test_pif_flags.sv ----
`timescale 1ns/10ps
module test_pif_flags
  import pif_pkg::*;
;
  logic              clock_i, reset_n_i, wr_i, rd_i, tx_rdy, rx_rdy, clr_buf, irq_o;
  logic [ADDR_W-1:0] addr_i;
  logic [7:0]        wdata_i, rdata_o, fire4, evt4, gpio, pins, f4_o, f5_o, w, f;
  logic [5:1]        fire5, evt5;
  logic              tx_cond, rx_cond;
  int                fail_count, check_count, seed;

  pif_src_model src (.clock_i(clock_i), .reset_n_i(reset_n_i), .fire4_i(fire4),
    .fire5_i(fire5), .pins_i(pins), .tx_ready_i(tx_rdy), .rx_ready_i(rx_rdy),
    .clear_buffers_bit_i(clr_buf), .evt4_o(evt4), .evt5_o(evt5), .gpio_o(gpio),
    .tx_cond_o(tx_cond), .rx_cond_o(rx_cond));
  pif_flags dut (.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .logic_cell1_evt_i(evt4[7]), .waveform_gen1_evt_i(evt4[6]), .num_osc1_evt_i(evt4[5]),
    .capture_compare1_evt_i(evt4[3]), .timer2_evt_i(evt4[2]), .timer1_gate_evt_i(evt4[1]),
    .timer1_evt_i(evt4[0]), .dma_ch2_abort_evt_i(evt5[5]), .dma_ch2_overrun_evt_i(evt5[4]),
    .dma_ch2_dest_count_evt_i(evt5[3]), .dma_ch2_src_count_evt_i(evt5[2]),
    .comparator2_evt_i(evt5[1]), .i2c_unit2_tx_cond_i(tx_cond),
    .i2c_unit2_rx_cond_i(rx_cond), .gpio_pins_i(gpio), .flags_group4_o(f4_o),
    .flags_group5_o(f5_o), .irq_o(irq_o));

  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clock_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clock_i);
    wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input string what, input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clock_i);
    rd_i <= 1'b0;
    #1 check(what, exp, rdata_o);
  endtask
  // strobe one cycle, then allow the model stage and the flag stage to land
  task automatic fire(input logic [7:0] a4, input logic [5:1] a5);
    @(posedge clock_i);
    fire4 <= a4;
    fire5 <= a5;
    @(posedge clock_i);
    fire4 <= 8'h00;
    fire5 <= 5'h00;
    repeat (2) @(posedge clock_i);
    #1;
  endtask
  task automatic i2c(input logic t, input logic r, input logic c);
    @(posedge clock_i);
    {tx_rdy, rx_rdy, clr_buf} <= {t, r, c};
    @(posedge clock_i);
    {tx_rdy, rx_rdy, clr_buf} <= 3'h0;
    repeat (2) @(posedge clock_i);
  endtask
  task automatic pin(input logic [7:0] p, input logic [7:0] exp5);
    @(posedge clock_i);
    pins <= p;
    repeat (4) @(posedge clock_i);
    #1 check("ext irq flag", exp5, f5_o);
  endtask
  function automatic logic [7:0] irq8();
    return {7'h00, irq_o};
  endfunction
  // what software reads back after writing d to a flag register
  function automatic logic [7:0] exp_g4(input logic [7:0] d);
    return d & G4_WR_MASK;
  endfunction
  function automatic logic [7:0] exp_g5(input logic [7:0] d);
    return d & G5_WR_MASK;
  endfunction

  initial begin
    #50000;
    fail_count++;
    summarize();
  end

  initial begin
    seed = $urandom(32'h8AB4);
    {reset_n_i, wr_i, rd_i, tx_rdy, rx_rdy, clr_buf} = 6'h00;
    {addr_i, wdata_i, fire4, fire5, pins} = '0;
    repeat (3) @(posedge clock_i);
    reset_n_i <= 1'b1;
    for (int a = 0; a < 16; a++) rd_chk("reset value", a[3:0], 8'h00);
    for (int i = 0; i < 8; i++) begin
      w = (i == 0) ? 8'hFF : (i == 1) ? 8'h10 : (i == 2) ? 8'hC0 : 8'($urandom);
      wr(OFF_FLAGS_GROUP4, w);
      rd_chk("group4 write", OFF_FLAGS_GROUP4, exp_g4(w));
      wr(OFF_FLAGS_GROUP5, ~w);
      rd_chk("group5 write", OFF_FLAGS_GROUP5, exp_g5(~w));
      check("irq masked", 8'h00, irq8());
    end
    wr(OFF_FLAGS_GROUP4, 8'h00);
    wr(OFF_FLAGS_GROUP5, 8'h00);
    for (int b = 0; b < 8; b++) begin
      f = 8'h01 << b;
      fire(f, f[5:1]);
      check("group4 event", exp_g4(f), f4_o);
      check("group5 event", f & 8'h3E, f5_o);
      check("irq masked", 8'h00, irq8());
      wr(OFF_FLAGS_GROUP4, 8'h00);
      wr(OFF_FLAGS_GROUP5, 8'h00);
      check("sw clear", 8'h00, f4_o | f5_o);
    end
    // flags were cleared above before any mask bit is opened
    wr(OFF_MASK_GROUP4, 8'h04);
    wr(OFF_MASK_GROUP5, 8'h20);
    rd_chk("mask4", OFF_MASK_GROUP4, 8'h04);
    // an unmapped write must leave every register alone
    wr(4'hF, 8'hFF);
    rd_chk("unmapped read", 4'hF, 8'h00);
    rd_chk("mask5 kept", OFF_MASK_GROUP5, 8'h20);
    @(posedge clock_i);
    #1 check("read idle", 8'h00, rdata_o);
    fire(8'h08, 5'h00);
    check("irq other bit", 8'h00, irq8());
    fire(8'h04, 5'h00);
    check("irq unmasked", 8'h01, irq8());
    wr(OFF_FLAGS_GROUP4, 8'h00);
    check("irq cleared", 8'h00, irq8());
    fire(8'h00, 5'h10);
    check("irq group5", 8'h01, irq8());
    wr(OFF_FLAGS_GROUP5, 8'h00);
    check("irq cleared5", 8'h00, irq8());
    @(posedge clock_i);
    fire4 <= 8'h01;
    @(posedge clock_i);
    fire4 <= 8'h00;
    wr_i <= 1'b1;
    addr_i <= OFF_FLAGS_GROUP4;
    wdata_i <= 8'h00;
    @(posedge clock_i);
    wr_i <= 1'b0;
    rd_chk("set beats clear", OFF_FLAGS_GROUP4, 8'h01);
    wr(OFF_FLAGS_GROUP4, 8'h00);
    i2c(1'b1, 1'b0, 1'b0);
    rd_chk("i2c tx", OFF_FLAGS_GROUP5, 8'h80);
    wr(OFF_FLAGS_GROUP5, 8'h00);
    i2c(1'b0, 1'b1, 1'b0);
    rd_chk("i2c rx read only", OFF_FLAGS_GROUP5, 8'hC0);
    i2c(1'b0, 1'b0, 1'b1);
    rd_chk("i2c flushed", OFF_FLAGS_GROUP5, 8'h00);
    wr(OFF_PIN_SELECT, 8'hF5);
    rd_chk("pin select", OFF_PIN_SELECT, 8'h05);
    pin(8'h04, 8'h00);
    pin(8'h24, 8'h01);
    wr(OFF_PIN_SELECT, 8'h0B);
    repeat (4) @(posedge clock_i);
    wr(OFF_FLAGS_GROUP5, 8'h00);
    pin(8'h08, 8'h00);
    pin(8'h00, 8'h01);
    fire(8'hEF, 5'h1F);
    @(posedge clock_i);
    reset_n_i <= 1'b0;
    @(posedge clock_i);
    reset_n_i <= 1'b1;
    #1 check("mid reset", 8'h00, f4_o | f5_o | irq8());
    rd_chk("mid reset mask", OFF_MASK_GROUP5, 8'h00);
    summarize();
  end
endmodule
